// ==== pkg/dics_pkg.sv ====
/*
 * constants, types and state layout of the two-wire command slave of a
 * 12-bit dac with a non-volatile backup word.
 * assumes a 10 MHz system clock and a bus master that drives the serial
 * clock.
 */
`default_nettype none

package dics_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int NVM_WRITE_NS = 25000000;
	localparam int NVM_WRITE_CYC =
		(NVM_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_W = 24;

	// ****************************************
	// bus codes
	// ****************************************
	localparam logic [7:0] GCALL_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [7:0] GC_WAKE = 8'h09;
	localparam logic [4:0] HS_PREFIX = 5'h01;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [2:0] RD_LAST = 3'h4;
	localparam logic [1:0] WR_CMD = 2'h0;
	localparam logic [1:0] WR_MID = 2'h1;
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] CMD_FAST = 2'h0;
	localparam logic [2:0] CMD_STORE = 3'h3;
	localparam logic POR_DONE = 1'h1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_GCALL = 3'h2,
		ST_WRITE = 3'h3,
		ST_READ = 3'h4,
		ST_IGNORE = 3'h5
	} dics_phase_t;

	typedef struct packed {
		logic powerdown_sel_hi;
		logic powerdown_sel_lo;
		logic [11:0] dac_code;
	} dics_word_t;

	localparam dics_word_t FACTORY_WORD = 14'h0800;

	typedef struct packed {
		logic [3:0] dev_code;
		logic addr_sel_bit2;
		logic addr_sel_bit1;
		logic addr_sel_pin_bit;
		logic rd;
	} dics_addr_t;

	typedef struct packed {
		logic cmd_type_bit2;
		logic cmd_type_bit1;
		logic cmd_type_bit0;
		logic [1:0] pad_hi;
		logic [1:0] pd;
		logic pad_lo;
	} dics_cmd_t;

	typedef struct packed {
		logic [1:0] cmd_hi;
		logic [1:0] pd;
		logic [3:0] code_hi;
	} dics_fast_t;

	typedef struct packed {
		logic rdy;
		logic por;
		logic [2:0] pad_hi;
		logic [1:0] pd;
		logic pad_lo;
	} dics_status_t;

	typedef struct packed {
		logic bit_val;
		logic tgl;
	} dics_link_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic a0_s1;
		logic a0_s2;
		logic tgl_s1;
		logic tgl_s2;
		logic tgl_d;
		dics_phase_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic [1:0] wr_idx;
		logic [2:0] rd_idx;
		logic ack_now;
		logic [7:0] tx_byte;
		logic sda_oe;
		logic sda_lvl;
		logic hs;
		logic [2:0] cap_cmd;
		logic [1:0] cap_pd;
		logic [11:0] cap_code;
		dics_word_t dac;
		dics_word_t nvm;
		logic [BUSY_W-1:0] busy_cnt;
		logic rdy;
	} dics_state_t;

endpackage

`default_nettype wire

// ==== src/dics_slave.sv ====
/*
 * two-wire serial slave and command interpreter of a 12-bit dac with a
 * non-volatile backup word: address match, write commands, read answer,
 * general calls and high-speed entry.
 * assumes scl_in is the master's serial clock, sda_in the resolved data
 * wire, and an open-drain pad built from sda_out and sda_oe_out.
 */
`timescale 1ns/1ps
`default_nettype none

module dics_slave
	import dics_pkg::*;
#(
	parameter logic [3:0] DEV_CODE = 4'ha, // arbitrary device code
	parameter logic [1:0] ADDR_HI_BITS = 2'h0,
	parameter int unsigned NVM_WRITE_CYCLES = NVM_WRITE_CYC
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic addr_sel_pin_in,
	output logic sda_out,
	output logic sda_oe_out,
	output dics_word_t dac_word_out,
	output dics_word_t nvm_word_out,
	output logic store_write_done_flag_out,
	output logic hs_mode_out
);

	// ****************************************
	// link side: bits taken on the serial clock
	// ****************************************
	dics_link_t lq;
	dics_link_t next_lq;

	always_comb begin
		next_lq = lq;
		next_lq.bit_val = sda_in;
		// the toggle, not the bit, crosses to the system clock
		// one toggle per rising serial clock edge
		next_lq.tgl = ~lq.tgl;
	end

	always_ff @(posedge scl_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lq <= '0;
		end else begin
			lq <= next_lq;
		end
	end

	// ****************************************
	// system side state
	// ****************************************
	localparam dics_state_t RST_Q = '{
		sda_oe: 1'h1,
		rdy: 1'h1,
		dac: FACTORY_WORD,
		nvm: FACTORY_WORD,
		st: ST_IDLE,
		default: '0
	};

	localparam logic [BUSY_W-1:0] BUSY_LOAD =
		BUSY_W'(NVM_WRITE_CYCLES);

	dics_state_t q;
	dics_state_t next_q;

	// ****************************************
	// read answer bytes
	// ****************************************
	function automatic logic [7:0] rd_byte(
		input logic [2:0] idx,
		input dics_state_t s
	);
		dics_status_t st_b;
		dics_fast_t nv_b;
		logic [15:0] code_w;
		st_b = '0;
		st_b.rdy = s.rdy;
		st_b.por = POR_DONE;
		st_b.pd = {s.dac.powerdown_sel_hi, s.dac.powerdown_sel_lo};
		nv_b.cmd_hi = {1'h0, s.nvm.powerdown_sel_hi};
		nv_b.pd = {s.nvm.powerdown_sel_lo, 1'h0};
		nv_b.code_hi = s.nvm.dac_code[11:8];
		code_w = {s.dac.dac_code, 4'h0};
		case (idx)
			3'h0: begin
				rd_byte = st_b;
			end
			3'h1: begin
				rd_byte = code_w[15:8];
			end
			3'h2: begin
				rd_byte = code_w[7:0];
			end
			3'h3: begin
				rd_byte = nv_b;
			end
			3'h4: begin
				rd_byte = s.nvm.dac_code[7:0];
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	endfunction

	// ****************************************
	// bus events and byte handling
	// ****************************************
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic bit_ev;
	logic [7:0] rx;
	dics_addr_t rx_addr;
	dics_cmd_t rx_cmd;
	dics_fast_t rx_fast;
	dics_word_t new_word;
	logic do_exec;

	// ****************************************
	// decoded address and command
	// ****************************************
	logic addr_hit;
	logic gcall_hit;
	logic hs_code_hit;
	logic cmd_fast;
	logic cap_fast;
	logic cap_reserved;
	logic cap_store;

	always_comb begin
		next_q = q;
		do_exec = 1'h0;
		new_word = q.dac;

		// ****************************************
		// synchronisers
		// ****************************************
		next_q.scl_s1 = scl_in;
		next_q.scl_s2 = q.scl_s1;
		next_q.scl_d = q.scl_s2;
		next_q.sda_s1 = sda_in;
		next_q.sda_s2 = q.sda_s1;
		next_q.sda_d = q.sda_s2;
		next_q.a0_s1 = addr_sel_pin_in;
		next_q.a0_s2 = q.a0_s1;
		next_q.tgl_s1 = lq.tgl;
		next_q.tgl_s2 = q.tgl_s1;
		next_q.tgl_d = q.tgl_s2;

		// ****************************************
		// bus events
		// ****************************************
		scl_fall = q.scl_d & ~q.scl_s2;
		start_ev = q.scl_d & q.scl_s2 & q.sda_d & ~q.sda_s2;
		stop_ev = q.scl_d & q.scl_s2 & ~q.sda_d & q.sda_s2;
		bit_ev = q.tgl_s2 ^ q.tgl_d;

		// ****************************************
		// byte views and decodes
		// ****************************************
		// the link bit is read only after the synced toggle, long settled
		rx = {q.shreg[6:0], lq.bit_val};
		rx_addr = rx;
		rx_cmd = rx;
		rx_fast = rx;
		addr_hit = (rx_addr.dev_code == DEV_CODE) &&
			({rx_addr.addr_sel_bit2, rx_addr.addr_sel_bit1} ==
			ADDR_HI_BITS) &&
			(rx_addr.addr_sel_pin_bit == q.a0_s2);
		gcall_hit = (rx == GCALL_ADDR);
		hs_code_hit = (rx[7:3] == HS_PREFIX);
		cmd_fast = (rx_fast.cmd_hi == CMD_FAST);
		cap_fast = (q.cap_cmd[2:1] == CMD_FAST);
		cap_reserved = q.cap_cmd[2];
		cap_store = (q.cap_cmd == CMD_STORE);

		// ****************************************
		// store write timer
		// ****************************************
		// a general call reset leaves a running store write alone
		if (q.busy_cnt != '0) begin
			next_q.busy_cnt = q.busy_cnt - 1'h1;
		end

		// ****************************************
		// received bit
		// ****************************************
		if (bit_ev) begin
			if (q.bit_cnt != ACK_SLOT) begin
				next_q.shreg = rx;
				next_q.bit_cnt = q.bit_cnt + 1'h1;
			end else begin
				next_q.bit_cnt = '0;
				next_q.ack_now = 1'h0;
				if (q.st == ST_READ && !q.ack_now) begin
					if (lq.bit_val) begin
						next_q.st = ST_IGNORE;
					end else begin
						next_q.tx_byte = rd_byte(q.rd_idx, q);
						// index wraps so the answer repeats while acked
						next_q.rd_idx = (q.rd_idx == RD_LAST) ?
							3'h0 : q.rd_idx + 1'h1;
					end
				end
			end

			// ****************************************
			// completed byte
			// ****************************************
			if (q.bit_cnt == BIT_LAST) begin
				next_q.ack_now = 1'h0;
				case (q.st)
					ST_ADDR: begin
						if (addr_hit) begin
							next_q.ack_now = 1'h1;
							if (rx_addr.rd) begin
								next_q.st = ST_READ;
								next_q.tx_byte = rd_byte(3'h0, q);
								next_q.rd_idx = 3'h1;
							end else begin
								next_q.st = ST_WRITE;
								next_q.wr_idx = WR_CMD;
							end
						end else if (gcall_hit) begin
							next_q.ack_now = 1'h1;
							next_q.st = ST_GCALL;
						end else if (hs_code_hit) begin
							next_q.hs = 1'h1;
							next_q.st = ST_IGNORE;
						end else begin
							next_q.st = ST_IGNORE;
						end
					end
					ST_GCALL: begin
						next_q.ack_now = 1'h1;
						next_q.st = ST_IGNORE;
						if (rx == GC_RESET) begin
							// power-on state of the write path, then reload
							next_q.wr_idx = WR_CMD;
							next_q.cap_cmd = '0;
							next_q.cap_pd = '0;
							next_q.cap_code = '0;
							next_q.rd_idx = '0;
							next_q.dac = q.nvm;
						end else if (rx == GC_WAKE) begin
							next_q.dac.powerdown_sel_hi = PD_NORMAL[1];
							next_q.dac.powerdown_sel_lo = PD_NORMAL[0];
						end
					end
					ST_WRITE: begin
						next_q.ack_now = 1'h1;
						case (q.wr_idx)
							WR_CMD: begin
								next_q.cap_cmd = rx[7:5];
								next_q.wr_idx = WR_MID;
								if (cmd_fast) begin
									next_q.cap_pd = rx_fast.pd;
									next_q.cap_code[3:0] = rx_fast.code_hi;
								end else begin
									next_q.cap_pd = rx_cmd.pd;
								end
							end
							WR_MID: begin
								if (cap_fast) begin
									new_word = {q.cap_pd,
										q.cap_code[3:0], rx};
									do_exec = 1'h1;
									next_q.wr_idx = WR_CMD;
								end else begin
									next_q.cap_code[7:0] = rx;
									next_q.wr_idx = q.wr_idx + 1'h1;
								end
							end
							default: begin
								// low nibble of the last byte is unused
								new_word = {q.cap_pd,
									q.cap_code[7:0], rx[7:4]};
								do_exec = 1'h1;
								next_q.wr_idx = WR_CMD;
							end
						endcase
					end
					ST_IGNORE, ST_IDLE: begin
						next_q.ack_now = 1'h0;
					end
					default: begin
						next_q.ack_now = 1'h0;
					end
				endcase
			end
		end

		// ****************************************
		// command execution
		// ****************************************
		if (do_exec && !cap_reserved && q.rdy) begin
			next_q.dac = new_word;
			if (cap_store) begin
				next_q.nvm = new_word;
				next_q.busy_cnt = BUSY_LOAD;
			end
		end

		// ****************************************
		// data line drive on the falling clock
		// ****************************************
		// data moves only after the synced fall, never with the clock high
		if (scl_fall) begin
			if (q.bit_cnt == ACK_SLOT) begin
				next_q.sda_oe = ~q.ack_now;
			end else if (q.st == ST_READ) begin
				next_q.sda_oe = q.tx_byte[7];
				next_q.tx_byte = {q.tx_byte[6:0], 1'h0};
			end else begin
				next_q.sda_oe = 1'h1;
			end
		end

		// ****************************************
		// start and stop
		// ****************************************
		// a start or a stop overrides the phase, bit count, ack and drive set above; a command executed in the same cycle still takes effect
		if (start_ev) begin
			// a partial write is simply dropped here
			next_q.st = ST_ADDR;
			next_q.bit_cnt = '0;
			next_q.ack_now = 1'h0;
			next_q.sda_oe = 1'h1;
		end else if (stop_ev) begin
			next_q.st = ST_IDLE;
			next_q.bit_cnt = '0;
			next_q.ack_now = 1'h0;
			next_q.sda_oe = 1'h1;
			next_q.hs = 1'h0;
		end

		// ****************************************
		// open-drain level and status
		// ****************************************
		next_q.sda_lvl = 1'h0;
		next_q.rdy = (next_q.busy_cnt == '0);
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= RST_Q;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// all outputs come straight from the state register
	assign sda_out = q.sda_lvl;
	assign sda_oe_out = q.sda_oe;
	assign dac_word_out = q.dac;
	assign nvm_word_out = q.nvm;
	assign store_write_done_flag_out = q.rdy;
	assign hs_mode_out = q.hs;

endmodule // dics_slave

`default_nettype wire

// ==== sim/dics_master.sv ====
/*
 * two-wire bus master model that drives the serial clock and data.
 * assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none

module dics_master (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	// ****************
	// bus phases
	// ****************
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic w(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// start from idle, or repeated start from a low clock
	task automatic start();
		sda_out = 1'b1;
		w(6);
		scl_out = 1'b1;
		w(6);
		sda_out = 1'b0;
		w(6);
		scl_out = 1'b0;
		w(1);
	endtask

	task automatic stop();
		sda_out = 1'b0;
		w(6);
		scl_out = 1'b1;
		w(6);
		sda_out = 1'b1;
		w(6);
	endtask

	// data only moves while the clock is low
	task automatic bio(input logic b, output logic r);
		sda_out = b;
		w(6);
		scl_out = 1'b1;
		w(3);
		r = sda_in;
		w(3);
		scl_out = 1'b0;
		w(1);
	endtask

	task automatic xb(input logic [7:0] b, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bio(b[i], r);
		end
		bio(1'b1, r);
		a = !r;
	endtask

	// no ack on the last byte lets the slave release
	task automatic rb(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bio(1'b1, r);
			b[i] = r;
		end
		bio(!ack, r);
	endtask
endmodule // dics_master

`default_nettype wire

// ==== sim/dics_slave_asserts.sv ====
/*
 * port assertions of the dac command slave.
 * assumes binding to every dics_slave instance.
 */
`timescale 1ns/1ps
`default_nettype none

module dics_slave_asserts
	import dics_pkg::*;
#(
	parameter int unsigned NVM_WRITE_CYCLES = 20
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic addr_sel_pin_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire dics_word_t dac_word_out,
	input wire dics_word_t nvm_word_out,
	input wire logic store_write_done_flag_out,
	input wire logic hs_mode_out
);
	// ****************
	// busy length
	// ****************
	int unsigned low_cnt;
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= store_write_done_flag_out ? 0 : low_cnt + 1;
		end
	end

	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);

	// ****************
	// checks
	// ****************
	sda_zero_a: assert property (sda_out == 1'b0)
		else $error("data value not low");
	pull_low_a: assert property ($fell(sda_oe_out) |-> !scl_in)
		else $error("pull while clock high");
	store_copy_a: assert property ($changed(nvm_word_out) |->
		nvm_word_out == dac_word_out ##1 !store_write_done_flag_out)
		else $error("store copy wrong");
	busy_len_a: assert property ($rose(store_write_done_flag_out) |->
		low_cnt == NVM_WRITE_CYCLES) else $error("busy length wrong");
	busy_hold_a: assert property (!store_write_done_flag_out &&
		!$past(store_write_done_flag_out) |-> $stable(nvm_word_out))
		else $error("store changed while busy");
	hs_enter_a: assert property ($rose(hs_mode_out) |-> sda_oe_out[*4])
		else $error("fast code acked");
	hs_exit_a: assert property ($fell(hs_mode_out) |-> scl_in && sda_in)
		else $error("fast mode left off stop");
	reset_val_a: assert property ($rose(arst_n_in) |->
		dac_word_out == FACTORY_WORD && store_write_done_flag_out &&
		!hs_mode_out) else $error("reset value wrong");

	cover property ($fell(store_write_done_flag_out));
	cover property ($rose(hs_mode_out));
	cover property ($changed(dac_word_out));
endmodule // dics_slave_asserts

bind dics_slave dics_slave_asserts #(
	.NVM_WRITE_CYCLES(NVM_WRITE_CYCLES)
) chk (
	.mclk_in(mclk_in),
	.arst_n_in(arst_n_in),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.addr_sel_pin_in(addr_sel_pin_in),
	.sda_out(sda_out),
	.sda_oe_out(sda_oe_out),
	.dac_word_out(dac_word_out),
	.nvm_word_out(nvm_word_out),
	.store_write_done_flag_out(store_write_done_flag_out),
	.hs_mode_out(hs_mode_out)
);

`default_nettype wire

// ==== sim/dics_slave_test.sv ====
/*
 * self-checking bench of the dac command slave.
 * assumes the master model and a pulled-up data wire.
 */
`timescale 1ns/1ps
`default_nettype none

module dics_slave_test
	import dics_pkg::*;
;
	// ****************
	// set-up
	// ****************
	localparam logic [3:0] DEV = 4'h5; // arbitrary device code
	localparam logic [7:0] WA = {DEV, 4'h2};
	localparam logic [7:0] RA = {DEV, 4'h3};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pin = 1'b1;
	logic scl, msda, oe, so, rdy, hs, ak;
	dics_word_t dac, nvm;
	wire logic sda = msda & (oe | so);
	int n_mismatch = 0;
	int compares = 0;

	always #50 clk = ~clk;

	dics_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(msda));
	dics_slave #(.DEV_CODE(DEV), .NVM_WRITE_CYCLES(2000)) dut (
		.mclk_in(clk),
		.arst_n_in(rst_n),
		.scl_in(scl),
		.sda_in(sda),
		.addr_sel_pin_in(pin),
		.sda_out(so),
		.sda_oe_out(oe),
		.dac_word_out(dac),
		.nvm_word_out(nvm),
		.store_write_done_flag_out(rdy),
		.hs_mode_out(hs)
	);

	// ****************
	// tasks
	// ****************
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tx(input logic [7:0] a, input logic e, input int n,
		input logic [55:0] d);
		logic k;
		m.start();
		m.xb(a, k);
		chk("address ack", {15'h0, e}, {15'h0, k});
		for (int i = 0; i < n; i++) begin
			m.xb(d[55 - 8 * i -: 8], k);
			chk("data ack", {15'h0, e}, {15'h0, k});
		end
		m.stop();
		$display("test write done at %0t", $time);
	endtask

	task automatic rd(input int n, input logic [47:0] e);
		logic k;
		logic [7:0] b;
		m.start();
		m.xb(RA, k);
		chk("read ack", 16'h1, {15'h0, k});
		for (int i = 0; i < n; i++) begin
			m.rb(i < n - 1, b);
			chk("read byte", {8'h0, e[47 - 8 * i -: 8]}, {8'h0, b});
		end
		m.stop();
		chk("released", 16'h1, {15'h0, oe});
		$display("test read done at %0t", $time);
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("dac reset", 16'h0800, {2'h0, dac});
		chk("nvm reset", 16'h0800, {2'h0, nvm});
		tx(WA, 1'b1, 2, {16'h1345, 40'h0});
		chk("fast", 16'h1345, {2'h0, dac});
		tx(WA, 1'b1, 3, {24'h44abcd, 32'h0});
		chk("reg", 16'h2abc, {2'h0, dac});
		tx(WA, 1'b1, 6, {24'h441110, 24'h40123f, 8'h0});
		chk("repeat", 16'h0123, {2'h0, dac});
		tx(WA, 1'b1, 2, {16'h4077, 40'h0});
		chk("partial", 16'h0123, {2'h0, dac});
		for (int c = 4; c < 8; c++) begin
			tx(WA, 1'b1, 3, {c[2:0], 5'h02, 16'h9990, 32'h0});
			chk("reserved", 16'h0123, {2'h0, dac});
		end
		tx({DEV, 4'h0}, 1'b0, 3, {24'h40fff0, 32'h0});
		chk("no match", 16'h0123, {2'h0, dac});
		tx({DEV, 4'h6}, 1'b0, 3, {24'h40fff0, 32'h0});
		chk("high bits", 16'h0123, {2'h0, dac});
		tx(WA, 1'b1, 3, {24'h665a50, 32'h0});
		chk("store dac", 16'h35a5, {2'h0, dac});
		chk("store nvm", 16'h35a5, {2'h0, nvm});
		chk("busy", 16'h0, {15'h0, rdy});
		tx(WA, 1'b1, 3, {24'h401110, 32'h0});
		chk("busy write", 16'h35a5, {2'h0, dac});
		rd(1, {8'h46, 40'h0});
		for (int i = 0; i < 3000 && rdy !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk("ready", 16'h1, {15'h0, rdy});
		if (rdy !== 1'b1) begin
			stop_test();
		end
		rd(6, {48'hc65a5065a5c6});
		tx(WA, 1'b1, 3, {24'h401230, 32'h0});
		chk("reg again", 16'h0123, {2'h0, dac});
		tx(8'h00, 1'b1, 1, {8'h06, 48'h0});
		chk("gc reset", 16'h35a5, {2'h0, dac});
		tx(8'h00, 1'b1, 1, {8'h09, 48'h0});
		chk("gc wake", 16'h05a5, {2'h0, dac});
		chk("gc nvm", 16'h35a5, {2'h0, nvm});
		m.start();
		m.xb(8'h0b, ak);
		chk("fast code ack", 16'h0, {15'h0, ak});
		chk("fast on", 16'h1, {15'h0, hs});
		m.stop();
		chk("fast off", 16'h0, {15'h0, hs});
		stop_test();
	end
endmodule // dics_slave_test

`default_nettype wire
